/* tgcu_gate_ctrl.sv */
// Gate control, counter and event logic of the 16-bit timer, with APB registers.
// Assumes neighbouring timers, watchdog clears and capture events arrive on sys_clk_in.
//
// The register addresses and the APB register port were chosen for this implementation.
`default_nettype none
module tgcu_gate_ctrl (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // APB slave
   input  wire logic [7:0]  paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Gate sources and timer clock
   input  wire logic        gate_input_pin_in,
   input  wire logic [7:0]  eight_bit_timer_in,
   input  wire logic [7:0]  period_timer_count_in,
   input  wire logic        count_tick_in,
   // System events
   input  wire logic        sleep_in,
   input  wire logic        watchdog_clear_in,
   input  wire logic        capture_event_in,
   input  wire logic        special_event_in,
   // Results
   output logic      [15:0] count_out,
   output logic             compare_match_out,
   output logic             overflow_irq_out,
   output logic             gate_irq_out,
   output logic             wake_out,
   output logic             vector_req_out,
   output logic      [15:0] vector_addr_out,
   output logic             wdt_reset_out,
   output logic             wdt_osc_on_out
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic rise_f(input logic prev, input logic cur);
      rise_f = ~prev & cur;
   endfunction

   tgcu_pkg::tgcu_state_t s_q, s_d;
   logic        src_raw, pol_lvl, rise, toggled, tg_rise, tg_fall, gate_val;
   logic        t0_wrap, t2_wrap, wdt_run, wtick, wclr, wdt_ovf, cnt_en, inc_ovf;
   logic        wr, setup, mapped;
   logic [7:0]  wmask;
   logic [31:0] rdata;

   // ----------------------------------------
   // Gate path
   // ----------------------------------------
   always_comb begin
      t0_wrap = (s_q.t0_prev == tgcu_pkg::T0_MAX) && (eight_bit_timer_in == 8'h00);
      t2_wrap = (s_q.t2_prev == s_q.period_limit) && (period_timer_count_in == 8'h00)
                && (s_q.t2_prev != 8'h00);
      case (s_q.gsrc)
         tgcu_pkg::GS_PIN: src_raw = s_q.pin_sync[1];
         tgcu_pkg::GS_T0:  src_raw = t0_wrap;
         tgcu_pkg::GS_T2:  src_raw = t2_wrap;
         default:          src_raw = wdt_ovf;
      endcase
      pol_lvl  = s_q.gate_pol ? src_raw : ~src_raw;
      rise     = rise_f(s_q.pol_q, pol_lvl);
      toggled  = s_q.tgl_en ? s_q.tff : pol_lvl;
      tg_rise  = rise_f(s_q.tg_q, toggled);
      tg_fall  = rise_f(toggled, s_q.tg_q);
      gate_val = s_q.sp_en ? (s_q.sp_run & toggled) : toggled;
   end

   // ----------------------------------------
   // Watchdog counter
   // ----------------------------------------
   always_comb begin
      wdt_run = s_q.wdt_en_cfg | (s_q.gate_en & (s_q.gsrc == tgcu_pkg::GS_WDT));
      wmask   = 8'((9'd1 << s_q.div_sel) - 9'd1);
      wtick   = wdt_run & (~s_q.div_assign | (s_q.wpre == wmask));
      wclr    = watchdog_clear_in | (sleep_in ^ s_q.sleep_q);
      wdt_ovf = wtick & (&s_q.wcnt) & ~wclr;
   end

   // ----------------------------------------
   // Counter enable and APB decode
   // ----------------------------------------
   always_comb begin
      cnt_en  = s_q.timer_on & (~s_q.gate_en | gate_val) & count_tick_in
                & (~sleep_in | s_q.async_sel);
      inc_ovf = cnt_en & (s_q.count == tgcu_pkg::COUNT_MAX);
      setup   = psel_in & ~penable_in;
      wr      = psel_in & penable_in & pwrite_in;
      mapped  = (paddr_in[1:0] == 2'b00) && (paddr_in <= tgcu_pkg::OFF_PERIOD);
      case (paddr_in)
         tgcu_pkg::OFF_CTRL:   rdata = {22'h00_0000, gate_val, s_q.gsrc, s_q.go_done, s_q.sp_en,
                                        s_q.tgl_en, s_q.gate_pol, s_q.gate_en, s_q.async_sel,
                                        s_q.timer_on};
         tgcu_pkg::OFF_COUNT:  rdata = {16'h0000, s_q.count};
         tgcu_pkg::OFF_STATUS: rdata = {30'h0000_0000, s_q.gev_flag, s_q.ovf_flag};
         tgcu_pkg::OFF_IRQEN:  rdata = {28'h000_0000, s_q.glob_ie, s_q.peri_ie, s_q.ovf_ie, s_q.gate_ie};
         tgcu_pkg::OFF_CAPT:   rdata = {16'h0000, s_q.capture};
         tgcu_pkg::OFF_CMP:    rdata = {16'h0000, s_q.compare};
         tgcu_pkg::OFF_WDT:    rdata = {27'h000_0000, s_q.div_sel, s_q.div_assign, s_q.wdt_en_cfg};
         tgcu_pkg::OFF_PERIOD: rdata = {24'h00_0000, s_q.period_limit};
         default:              rdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.pin_sync = {s_q.pin_sync[0], gate_input_pin_in};
      s_d.t0_prev  = eight_bit_timer_in;
      s_d.t2_prev  = period_timer_count_in;
      s_d.pol_q    = pol_lvl;
      s_d.tg_q     = toggled;
      s_d.gval_q   = gate_val;
      s_d.sleep_q  = sleep_in;
      if (setup) begin
         s_d.prdata = rdata;
      end
      // Toggle flip-flop.
      if (!s_q.tgl_en || !s_q.timer_on) begin
         s_d.tff = 1'b0;
      end else if (rise) begin
         s_d.tff = ~s_q.tff;
      end
      // Single-pulse sequencing.
      if (!s_q.sp_en || !s_q.go_done) begin
         s_d.sp_run = 1'b0;
      end else if (s_q.sp_run && tg_fall) begin
         s_d.sp_run  = 1'b0;
         s_d.go_done = 1'b0;
      end else if (tg_rise) begin
         s_d.sp_run = 1'b1;
      end
      // Watchdog.
      if (wclr || !wdt_run) begin
         s_d.wpre = 8'h00;
         s_d.wcnt = '0;
      end else if (wtick) begin
         s_d.wpre = 8'h00;
         s_d.wcnt = s_q.wcnt + 1'b1;
      end else begin
         s_d.wpre = s_q.wpre + 8'h01;
      end
      s_d.wdt_rst = wdt_ovf & s_q.wdt_en_cfg & ~sleep_in;
      s_d.wake    = sleep_in & ((wdt_ovf & s_q.wdt_en_cfg)
                    | (inc_ovf & s_q.timer_on & s_q.ovf_ie & s_q.peri_ie));
      s_d.vec_req = s_d.wake & s_q.glob_ie;
      // Counter, capture and compare.
      if (cnt_en) begin
         s_d.count = s_q.count + 16'h0001;
      end
      if (special_event_in) begin
         s_d.count = 16'h0000;
      end
      if (capture_event_in) begin
         s_d.capture = s_q.count;
      end
      s_d.cmp_hit = (s_q.compare == s_q.count);
      // Register writes.
      if (wr) begin
         case (paddr_in)
            tgcu_pkg::OFF_CTRL: begin
               s_d.timer_on  = pwdata_in[tgcu_pkg::CB_TON];
               s_d.async_sel = pwdata_in[tgcu_pkg::CB_ASY];
               s_d.gate_en   = pwdata_in[tgcu_pkg::CB_GEN];
               s_d.gate_pol  = pwdata_in[tgcu_pkg::CB_POL];
               s_d.tgl_en    = pwdata_in[tgcu_pkg::CB_TGL];
               s_d.sp_en     = pwdata_in[tgcu_pkg::CB_SPM];
               s_d.go_done   = pwdata_in[tgcu_pkg::CB_GO] & pwdata_in[tgcu_pkg::CB_SPM];
               s_d.gsrc      = tgcu_pkg::tgcu_gsrc_t'(pwdata_in[tgcu_pkg::CB_GSS +: 2]);
            end
            tgcu_pkg::OFF_COUNT: begin
               if (pstrb_in[0]) begin
                  s_d.count[7:0] = pwdata_in[7:0];
               end
               if (pstrb_in[1]) begin
                  s_d.count[15:8] = pwdata_in[15:8];
               end
            end
            tgcu_pkg::OFF_STATUS: begin
               s_d.ovf_flag = s_q.ovf_flag & ~pwdata_in[tgcu_pkg::SB_OVF];
               s_d.gev_flag = s_q.gev_flag & ~pwdata_in[tgcu_pkg::SB_GEV];
            end
            tgcu_pkg::OFF_IRQEN: begin
               s_d.gate_ie = pwdata_in[tgcu_pkg::IB_GATE];
               s_d.ovf_ie  = pwdata_in[tgcu_pkg::IB_OVF];
               s_d.peri_ie = pwdata_in[tgcu_pkg::IB_PERI];
               s_d.glob_ie = pwdata_in[tgcu_pkg::IB_GLOB];
            end
            tgcu_pkg::OFF_CMP: begin
               s_d.compare = pwdata_in[15:0];
            end
            tgcu_pkg::OFF_WDT: begin
               s_d.wdt_en_cfg = pwdata_in[tgcu_pkg::WB_EN];
               s_d.div_assign = pwdata_in[tgcu_pkg::WB_PSA];
               s_d.div_sel    = pwdata_in[tgcu_pkg::WB_PS +: 3];
            end
            tgcu_pkg::OFF_PERIOD: begin
               s_d.period_limit = pwdata_in[7:0];
            end
            default: begin
               s_d.prdata = s_d.prdata;
            end
         endcase
      end
      // Hardware sets win over software clears.
      if (inc_ovf) begin
         s_d.ovf_flag = 1'b1;
      end
      if (rise_f(gate_val, s_q.gval_q)) begin
         s_d.gev_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata_out        = s_q.prdata;
   assign pready_out        = psel_in & penable_in;
   assign pslverr_out       = psel_in & penable_in & ~mapped;
   assign count_out         = s_q.count;
   assign compare_match_out = s_q.cmp_hit;
   assign overflow_irq_out  = s_q.ovf_flag & s_q.timer_on & s_q.ovf_ie
                              & s_q.peri_ie & s_q.glob_ie;
   assign gate_irq_out      = s_q.gev_flag & s_q.gate_ie;
   assign wake_out          = s_q.wake;
   assign vector_req_out    = s_q.vec_req;
   assign vector_addr_out   = tgcu_pkg::ISR_VECTOR;
   assign wdt_reset_out     = s_q.wdt_rst;
   assign wdt_osc_on_out    = wdt_run;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence sp_armed_s;
      s_q.sp_en && s_q.go_done && s_q.sp_run;
   endsequence
   sequence trailing_s;
      tg_fall;
   endsequence

   gate_pin_sel_a: assert property ((s_q.gsrc == tgcu_pkg::GS_PIN) |-> src_raw == s_q.pin_sync[1])
      else $error("Pin source not routed to gate.");
   gate_polarity_a: assert property (!s_q.gate_pol && !s_q.tgl_en |-> toggled == !src_raw)
      else $error("Active-low polarity not applied.");
   t0_wrap_pulse_a: assert property ((s_q.gsrc == tgcu_pkg::GS_T0) && $past(eight_bit_timer_in) == 8'hFF
      && eight_bit_timer_in == 8'h00 |-> src_raw)
      else $error("Eight-bit wrap gave no gate pulse.");
   wdt_auto_run_a: assert property (s_q.gate_en && s_q.gsrc == tgcu_pkg::GS_WDT |-> wdt_osc_on_out)
      else $error("Watchdog not running for gate use.");
   wdt_quiet_a: assert property (!s_q.wdt_en_cfg |=> !wdt_reset_out && !s_q.wdt_rst)
      else $error("Gating watchdog caused a reset.");
   wdt_restart_a: assert property (watchdog_clear_in |=> s_q.wcnt == '0)
      else $error("Watchdog clear did not restart count.");
   tff_flip_a: assert property (s_q.tgl_en && s_q.timer_on && rise |=> s_q.tff != $past(s_q.tff))
      else $error("Toggle flip-flop did not invert.");
   tff_hold_a: assert property (!s_q.tgl_en || !s_q.timer_on |=> !s_q.tff)
      else $error("Toggle flip-flop not held clear.");
   sp_done_a: assert property (sp_armed_s ##0 trailing_s |=> !s_q.go_done && !s_q.sp_run [*2])
      else $error("Single pulse not closed on trailing edge.");
   spm_clear_a: assert property (wr && paddr_in == tgcu_pkg::OFF_CTRL && !pwdata_in[tgcu_pkg::CB_SPM]
      |=> !s_q.go_done)
      else $error("Go/done survived single-pulse disable.");
   gev_set_a: assert property (s_q.gval_q && !gate_val |=> s_q.gev_flag)
      else $error("Gate event flag not set on falling level.");
   ovf_set_a: assert property (cnt_en && s_q.count == 16'hFFFF |=> s_q.ovf_flag && s_q.count == 16'h0000
      || $past(wr))
      else $error("Rollover did not set overflow flag.");
   ovf_irq_a: assert property (overflow_irq_out |-> s_q.timer_on && s_q.ovf_ie && s_q.peri_ie
      && s_q.glob_ie && s_q.ovf_flag)
      else $error("Overflow interrupt without all enables.");
   sev_clear_a: assert property (special_event_in && !wr && s_q.count != 16'hFFFF
      |=> s_q.count == 16'h0000 && $stable(s_q.ovf_flag) [*1])
      else $error("Special event did not clear quietly.");
   count_hold_a: assert property (!cnt_en && !wr && !special_event_in |=> $stable(s_q.count))
      else $error("Counter moved while gate inactive.");
endmodule
`default_nettype wire

/* tgcu_pkg.sv */
// Constants, types and register map of the timer gate control unit.
// Assumes a single 40 MHz system clock and an APB master on the register port.
`default_nettype none
package tgcu_pkg;
   // ----------------------------------------
   // Register offsets and bit positions
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_COUNT  = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQEN  = 8'h0C;
   localparam logic [7:0] OFF_CAPT   = 8'h10;
   localparam logic [7:0] OFF_CMP    = 8'h14;
   localparam logic [7:0] OFF_WDT    = 8'h18;
   localparam logic [7:0] OFF_PERIOD = 8'h1C;
   localparam int CB_TON = 0, CB_ASY = 1, CB_GEN = 2, CB_POL = 3, CB_TGL = 4;
   localparam int CB_SPM = 5, CB_GO = 6, CB_GSS = 7, CB_GVAL = 9;
   localparam int SB_OVF = 0, SB_GEV = 1;
   localparam int IB_GATE = 0, IB_OVF = 1, IB_PERI = 2, IB_GLOB = 3;
   localparam int WB_EN = 0, WB_PSA = 1, WB_PS = 2;
   localparam logic [15:0] ISR_VECTOR = 16'h0004;
   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
   localparam logic [7:0]  T0_MAX     = 8'hFF;
   localparam int WDT_W = 10;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      GS_PIN = 2'b00, GS_T0 = 2'b01, GS_T2 = 2'b10, GS_WDT = 2'b11
   } tgcu_gsrc_t;
   typedef struct packed {
      logic [1:0]       pin_sync;
      logic             timer_on, async_sel, gate_en, gate_pol, tgl_en, sp_en, go_done;
      tgcu_gsrc_t       gsrc;
      logic [15:0]      count, capture, compare;
      logic             ovf_flag, gev_flag;
      logic             gate_ie, ovf_ie, peri_ie, glob_ie;
      logic             wdt_en_cfg, div_assign;
      logic [2:0]       div_sel;
      logic [7:0]       period_limit, t0_prev, t2_prev, wpre;
      logic [WDT_W-1:0] wcnt;
      logic             tff, pol_q, tg_q, sp_run, gval_q, sleep_q;
      logic             wdt_rst, wake, vec_req, cmp_hit;
      logic [31:0]      prdata;
   } tgcu_state_t;
endpackage
`default_nettype wire

/* tgcu_far_model.sv */
// Far-side model: sibling eight-bit timer, period timer and timer clock tick source.
// Assumes the bench steps each source through its run inputs on sys_clk_in.
`default_nettype none
module tgcu_far_model (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   // Run controls
   input  wire logic       t0_run_in,
   input  wire logic       t2_run_in,
   input  wire logic       tick_run_in,
   input  wire logic [7:0] limit_in,
   // Gate sources and timer clock tick
   output logic      [7:0] eight_bit_timer_out,
   output logic      [7:0] period_timer_count_out,
   output logic            count_tick_out
);
   timeunit 1ns;
   timeprecision 1ps;
   assign count_tick_out = tick_run_in;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         eight_bit_timer_out    <= 8'h00;
         period_timer_count_out <= 8'h00;
      end else begin
         if (t0_run_in) begin
            eight_bit_timer_out <= eight_bit_timer_out + 8'h01;
         end
         if (t2_run_in) begin
            period_timer_count_out <= (period_timer_count_out == limit_in) ? 8'h00
                                    : period_timer_count_out + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* tgcu_gate_ctrl_tb.sv */
// Self-checking bench of the timer gate control unit over APB.
// Assumes tgcu_pkg, tgcu_gate_ctrl and tgcu_far_model are compiled first.
`default_nettype none
module tgcu_gate_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000, prdata_out;
   logic        pin = 1'b0, sleep_in = 1'b0, wclr = 1'b0, capt = 1'b0, spev = 1'b0;
   logic        t0_run = 1'b0, t2_run = 1'b0, tick_run = 1'b0, tick, pready_out, pslverr_out;
   logic [7:0]  t0_val, t2_val;
   logic [15:0] count_out, vector_addr_out;
   logic        cmp_out, ovf_irq, gate_irq, wake_out, vec_out, wdt_rst, wdt_osc;
   int          mismatches = 0, comparisons = 0, cycles = 0, n_wdt = 0, n_wake = 0, n_vec = 0, w;
   tgcu_far_model i_far (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .t0_run_in(t0_run), .t2_run_in(t2_run),
      .tick_run_in(tick_run), .limit_in(8'h05), .eight_bit_timer_out(t0_val),
      .period_timer_count_out(t2_val), .count_tick_out(tick));
   tgcu_gate_ctrl i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .pstrb_in(4'hF),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .gate_input_pin_in(pin), .eight_bit_timer_in(t0_val), .period_timer_count_in(t2_val),
      .count_tick_in(tick), .sleep_in(sleep_in), .watchdog_clear_in(wclr), .capture_event_in(capt),
      .special_event_in(spev), .count_out(count_out), .compare_match_out(cmp_out),
      .overflow_irq_out(ovf_irq), .gate_irq_out(gate_irq), .wake_out(wake_out), .vector_req_out(vec_out),
      .vector_addr_out(vector_addr_out), .wdt_reset_out(wdt_rst), .wdt_osc_on_out(wdt_osc));
   always #12.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles++;
      n_wdt += int'(wdt_rst === 1'b1);
      n_wake += int'(wake_out === 1'b1);
      n_vec += int'(vec_out === 1'b1);
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      @(posedge sys_clk_in);
      while (pready_out !== 1'b1) begin
         @(posedge sys_clk_in);
         n++;
      end
      r = prdata_out;
      chk("pslverr", {31'h0, a > 8'h1C}, {31'h0, pslverr_out});
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(nm, e, r & m);
   endtask
   task automatic ctl(input logic [6:0] b, input logic [1:0] s);
      wr(tgcu_pkg::OFF_CTRL, {23'h00_0000, s, b});
   endtask
   task automatic step(input logic [15:0] e);
      tick_run <= 1'b1;
      cyc(6);
      tick_run <= 1'b0;
      cyc(3);
      rdc(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF, {16'h0000, e}, "count");
   endtask
   task automatic pulse(input logic tk);
      pin <= 1'b1;
      cyc(4);
      if (tk) begin
         tick_run <= 1'b1;
         cyc(6);
         tick_run <= 1'b0;
      end
      pin <= 1'b0;
      cyc(4);
   endtask
   initial begin
      cyc(16);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      rdc(tgcu_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0200, "ctrl reset");
      rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
      wr(tgcu_pkg::OFF_CAPT, 32'h0000_1234);
      rdc(tgcu_pkg::OFF_CAPT, 32'hFFFF_FFFF, 32'h0000_0000, "capture read only");
      chk("vector", 32'h0000_0004, {16'h0000, vector_addr_out});
      $display("test reset done");
      wr(tgcu_pkg::OFF_IRQEN, 32'h0000_0001);
      ctl(7'h0D, 2'b00);
      step(16'h0000);
      pin <= 1'b1;
      cyc(4);
      rdc(tgcu_pkg::OFF_CTRL, 32'h0000_0200, 32'h0000_0200, "gate level");
      step(16'h0006);
      ctl(7'h09, 2'b00);
      pin <= 1'b0;
      cyc(4);
      chk("gate irq", 32'h0000_0001, {31'h0, gate_irq});
      rdc(tgcu_pkg::OFF_STATUS, 32'h0000_0002, 32'h0000_0002, "gate flag");
      wr(tgcu_pkg::OFF_STATUS, 32'h0000_0002);
      chk("gate irq clear", 32'h0000_0000, {31'h0, gate_irq});
      ctl(7'h05, 2'b00);
      step(16'h000C);
      $display("test gate pin done");
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0000);
      ctl(7'h1D, 2'b00);
      step(16'h0000);
      pulse(1'b0);
      step(16'h0006);
      pulse(1'b0);
      step(16'h0006);
      pulse(1'b0);
      ctl(7'h0D, 2'b00);
      ctl(7'h1D, 2'b00);
      step(16'h0006);
      pulse(1'b0);
      ctl(7'h1C, 2'b00);
      ctl(7'h1D, 2'b00);
      step(16'h0006);
      $display("test toggle done");
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0000);
      ctl(7'h2D, 2'b00);
      ctl(7'h6D, 2'b00);
      pulse(1'b1);
      rdc(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF, 32'h0000_0006, "single pulse count");
      rdc(tgcu_pkg::OFF_CTRL, 32'h0000_0040, 32'h0000_0000, "go done cleared");
      pulse(1'b1);
      rdc(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF, 32'h0000_0006, "single pulse held");
      ctl(7'h6D, 2'b00);
      ctl(7'h0D, 2'b00);
      rdc(tgcu_pkg::OFF_CTRL, 32'h0000_0040, 32'h0000_0000, "go done off");
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0000);
      ctl(7'h3D, 2'b00);
      ctl(7'h7D, 2'b00);
      pulse(1'b0);
      step(16'h0006);
      pulse(1'b0);
      step(16'h0006);
      $display("test single pulse done");
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0000);
      wr(tgcu_pkg::OFF_PERIOD, 32'h0000_0005);
      ctl(7'h0D, 2'b01);
      tick_run <= 1'b1;
      t0_run <= 1'b1;
      cyc(300);
      t0_run <= 1'b0;
      cyc(4);
      ctl(7'h0D, 2'b10);
      t2_run <= 1'b1;
      cyc(18);
      t2_run <= 1'b0;
      cyc(4);
      tick_run <= 1'b0;
      rdc(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF, 32'h0000_0004, "source pulses");
      ctl(7'h14, 2'b11);
      cyc(2);
      chk("watchdog osc", 32'h0000_0001, {31'h0, wdt_osc});
      w = n_wdt;
      cyc(1100);
      chk("watchdog reset off", 32'h0000_0000, 32'(n_wdt - w));
      wr(tgcu_pkg::OFF_WDT, 32'h0000_0001);
      w = n_wdt;
      cyc(1100);
      chk("watchdog reset on", 32'h0000_0001, {31'h0, n_wdt > w});
      w = n_wdt;
      repeat (4) begin
         wclr <= 1'b1;
         cyc(1);
         wclr <= 1'b0;
         cyc(500);
      end
      chk("watchdog cleared", 32'h0000_0000, 32'(n_wdt - w));
      wr(tgcu_pkg::OFF_WDT, 32'h0000_0000);
      ctl(7'h00, 2'b00);
      cyc(2);
      chk("watchdog osc off", 32'h0000_0000, {31'h0, wdt_osc});
      $display("test sources done");
      ctl(7'h01, 2'b00);
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_FFFE);
      step(16'h0004);
      rdc(tgcu_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "overflow flag");
      chk("ovf irq masked", 32'h0000_0000, {31'h0, ovf_irq});
      wr(tgcu_pkg::OFF_IRQEN, 32'h0000_000E);
      chk("ovf irq", 32'h0000_0001, {31'h0, ovf_irq});
      wr(tgcu_pkg::OFF_IRQEN, 32'h0000_0006);
      chk("ovf irq global", 32'h0000_0000, {31'h0, ovf_irq});
      wr(tgcu_pkg::OFF_IRQEN, 32'h0000_000E);
      ctl(7'h00, 2'b00);
      chk("ovf irq timer off", 32'h0000_0000, {31'h0, ovf_irq});
      wr(tgcu_pkg::OFF_STATUS, 32'h0000_0003);
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0055);
      spev <= 1'b1;
      cyc(1);
      spev <= 1'b0;
      cyc(2);
      rdc(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF, 32'h0000_0000, "special clear");
      rdc(tgcu_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "no overflow");
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_0321);
      capt <= 1'b1;
      cyc(1);
      capt <= 1'b0;
      cyc(2);
      rdc(tgcu_pkg::OFF_CAPT, 32'h0000_FFFF, 32'h0000_0321, "capture");
      wr(tgcu_pkg::OFF_CMP, 32'h0000_0321);
      cyc(2);
      chk("compare", 32'h0000_0001, {31'h0, cmp_out});
      $display("test overflow done");
      ctl(7'h01, 2'b00);
      wr(tgcu_pkg::OFF_COUNT, 32'h0000_FFFF);
      sleep_in <= 1'b1;
      w = n_wake + n_vec;
      step(16'hFFFF);
      ctl(7'h03, 2'b00);
      step(16'h0005);
      sleep_in <= 1'b0;
      chk("wake and vector", 32'h0000_0002, 32'(n_wake + n_vec - w));
      chk("count out", 32'h0000_0005, {16'h0000, count_out});
      $display("test sleep done");
      finish_test();
   end
endmodule
`default_nettype wire
